// file: src/apfp_pkg.sv
// shared constants for the asynchronous parallel fifo port
package apfp_pkg;
	localparam int unsigned APFP_DATA_W      = 8;
	localparam int unsigned APFP_CHANNELS    = 2;
	// channel select encoding
	localparam logic        APFP_CHAN_ONE    = 1'b0;
	localparam logic        APFP_CHAN_TWO    = 1'b1;
	// reset values of the handshake flags (inactive high)
	localparam logic        APFP_FLAG_RST    = 1'b1;
	localparam logic [7:0]  APFP_DATA_RST    = 8'h00;
	// send-now pulse must be seen low this many ns, then rounded up to whole synchronised cycles; the port acts on its first synchronised low sample
	localparam int unsigned APFP_SEND_LOW_NS  = 50;
	localparam int unsigned APFP_CLK_PERIOD_NS = 25;
	localparam int unsigned APFP_SEND_LOW_CYC =
		(APFP_SEND_LOW_NS + APFP_CLK_PERIOD_NS - 1) / APFP_CLK_PERIOD_NS;
	localparam logic [1:0]  APFP_SEND_LOW_CNT = 2'(APFP_SEND_LOW_CYC);

	typedef enum logic [1:0] {
		APFP_RD_IDLE  = 2'b00,
		APFP_RD_DRIVE = 2'b01,
		APFP_RD_ADV   = 2'b10
	} apfp_rd_state_t;
endpackage

// file: src/apfp_sync.sv
// two flip-flop synchroniser for a pin level
module apfp_sync
	import apfp_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// level in and out
	input  wire logic pin_in,
	output logic      level_out
);
	logic meta_q;
	logic meta_d;
	logic level_q;
	logic level_d;

	always_comb begin
		meta_d  = pin_in;
		level_d = meta_q;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q  <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			meta_q  <= meta_d;
			level_q <= level_d;
		end
	end

	assign level_out = level_q;
endmodule

// file: src/apfp_edge.sv
// falling and rising edge detector on a synchronised level
module apfp_edge
	import apfp_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// level and edges
	input  wire logic level_in,
	output logic      fall_out,
	output logic      rise_out
);
	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = level_in;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign fall_out = prev_q & ~level_in;
	assign rise_out = ~prev_q & level_in;
endmodule

// file: src/apfp_port.sv
// asynchronous byte fifo port between usb buffers and an external master
// How it works
// - each channel enters this mode independently from a stored configuration bit
// - the port serves channel one or two with identical pin functions
// - bytes move on falling edges of read and write strobes, no interface clock
// - data bus is input except while the read strobe is low
// - during reset the space flag is undriven and pulled high
// - read strobe falling puts the receive head byte on the bus
// - read strobe rising advances to the next receive byte if present
// - a write strobe fall captures the bus byte into the transmit buffer only while no byte is already held
// - suspended and wakeup enabled, a send-now low pulse requests resume
// - not suspended, a send-now low pulse flushes pending transmit data
// - high data flag forbids reads, low flag means data may be read
module apfp_port
	import apfp_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// configuration
	input  wire logic [1:0] fifo_mode_en,
	input  wire logic       chan_sel,
	input  wire logic       wakeup_en,
	input  wire logic       power_enable_n,
	// receive buffer side (usb to master)
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	output logic            rx_ready,
	// transmit buffer side (master to usb)
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	input  wire logic       tx_ready,
	output logic            send_now,
	output logic            resume_req,
	// pins
	input  wire logic [7:0] chan_data_i,
	output logic [7:0]      chan_data_o,
	output logic            chan_data_oe,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       send_now_wakeup_n,
	output logic            rx_data_avail_n,
	output logic            tx_space_avail_n_o,
	output logic            tx_space_avail_n_oe
);
	logic           rd_s;
	logic           wr_s;
	logic           send_now_wakeup_n_s;
	logic           rd_fall;
	logic           rd_rise;
	logic           wr_fall;
	logic           send_now_wakeup_n_fall;
	logic [7:0]     data_s;
	logic [7:0]     meta_data_q;
	logic [7:0]     meta_data_d;
	logic [7:0]     data_d;
	logic           active;

	apfp_rd_state_t rd_state_q;
	apfp_rd_state_t rd_state_d;
	logic [7:0]     out_q;
	logic [7:0]     out_d;
	logic           oe_q;
	logic           oe_d;
	logic           rx_pop_q;
	logic           rx_pop_d;
	logic           tx_full_q;
	logic           tx_full_d;
	logic [7:0]     tx_q;
	logic [7:0]     tx_d;
	logic           rst_seen_q;
	logic           rst_seen_d;
	logic           send_q;
	logic           send_d;
	logic           res_q;
	logic           res_d;
	logic [7:0]     data_q;

	// strobe and send-now synchronisers
	apfp_sync #(.RST_VAL(1'b1)) u_rd_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (rd_n),
		.level_out (rd_s)
	);
	apfp_sync #(.RST_VAL(1'b1)) u_wr_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (wr_n),
		.level_out (wr_s)
	);
	apfp_sync #(.RST_VAL(1'b1)) u_sw_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (send_now_wakeup_n),
		.level_out (send_now_wakeup_n_s)
	);
	apfp_edge u_rd_edge (
		.core_clk (core_clk),
		.rst      (rst),
		.level_in (rd_s),
		.fall_out (rd_fall),
		.rise_out (rd_rise)
	);
	apfp_edge u_wr_edge (
		.core_clk (core_clk),
		.rst      (rst),
		.level_in (wr_s),
		.fall_out (wr_fall),
		.rise_out ()
	);
	apfp_edge u_sw_edge (
		.core_clk (core_clk),
		.rst      (rst),
		.level_in (send_now_wakeup_n_s),
		.fall_out (send_now_wakeup_n_fall),
		.rise_out ()
	);

	// data bus synchroniser, aligned with the strobe path
	always_comb begin
		meta_data_d = chan_data_i;
		data_d      = meta_data_q;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_data_q <= APFP_DATA_RST;
			data_q      <= APFP_DATA_RST;
		end else begin
			meta_data_q <= meta_data_d;
			data_q      <= data_d;
		end
	end
	assign data_s = data_q;

	// mode enable for the selected channel
	assign active = (chan_sel == APFP_CHAN_TWO) ? fifo_mode_en[1] : fifo_mode_en[0];

	// read path
	always_comb begin
		rd_state_d = rd_state_q;
		out_d      = out_q;
		oe_d       = oe_q;
		rx_pop_d   = 1'b0;
		case (rd_state_q)
			APFP_RD_IDLE: begin
				if (active && rd_fall) begin
					out_d      = rx_valid ? rx_data : out_q;
					oe_d       = 1'b1;
					rd_state_d = APFP_RD_DRIVE;
				end
			end
			APFP_RD_DRIVE: begin
				if (rd_rise) begin
					oe_d       = 1'b0;
					rx_pop_d   = rx_valid;
					rd_state_d = APFP_RD_ADV;
				end
			end
			APFP_RD_ADV: begin
				rd_state_d = APFP_RD_IDLE;
			end
			default: begin
				rd_state_d = APFP_RD_IDLE;
				oe_d       = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_state_q <= APFP_RD_IDLE;
			out_q      <= APFP_DATA_RST;
			oe_q       <= 1'b0;
			rx_pop_q   <= 1'b0;
		end else begin
			rd_state_q <= rd_state_d;
			out_q      <= out_d;
			oe_q       <= oe_d;
			rx_pop_q   <= rx_pop_d;
		end
	end

	assign rx_ready        = rx_pop_q;
	assign chan_data_o     = out_q;
	assign chan_data_oe    = oe_q;
	assign rx_data_avail_n = ~(active && rx_valid && rd_state_q == APFP_RD_IDLE);

	// write path, single holding byte towards the transmit buffer
	always_comb begin
		tx_full_d  = tx_full_q;
		tx_d       = tx_q;
		if (tx_full_q && tx_ready) begin
			tx_full_d = 1'b0;
		end
		if (active && wr_fall && !tx_full_q) begin
			tx_d      = data_s;
			tx_full_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_full_q <= 1'b0;
			tx_q      <= APFP_DATA_RST;
		end else begin
			tx_full_q <= tx_full_d;
			tx_q      <= tx_d;
		end
	end

	assign tx_valid = tx_full_q;
	assign tx_data  = tx_q;

	// space flag released only after reset has been left
	always_comb begin
		rst_seen_d = 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_seen_q <= 1'b0;
		end else begin
			rst_seen_q <= rst_seen_d;
		end
	end
	assign tx_space_avail_n_oe = rst_seen_q & ~rst;
	assign tx_space_avail_n_o  = ~(active && !tx_full_q);

	// send-now and wakeup
	always_comb begin
		send_d = 1'b0;
		res_d  = 1'b0;
		if (active && send_now_wakeup_n_fall) begin
			if (power_enable_n && wakeup_en) begin
				res_d = 1'b1;
			end else if (!power_enable_n) begin
				send_d = 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			send_q <= 1'b0;
			res_q  <= 1'b0;
		end else begin
			send_q <= send_d;
			res_q  <= res_d;
		end
	end
	assign send_now   = send_q;
	assign resume_req = res_q;

	// checks
	bus_drive_rd_a: assert property (@(posedge core_clk) disable iff (rst)
		chan_data_oe |-> rd_state_q == APFP_RD_DRIVE)
		else $error("data bus driven outside a read");
	read_head_a: assert property (@(posedge core_clk) disable iff (rst)
		(rd_state_q == APFP_RD_IDLE && active && rd_fall && rx_valid)
		|=> (chan_data_o == $past(rx_data) && chan_data_oe))
		else $error("head byte not placed on bus");
	read_adv_a: assert property (@(posedge core_clk) disable iff (rst)
		(rd_state_q == APFP_RD_DRIVE && rd_rise && rx_valid) |=> rx_ready)
		else $error("receive buffer not advanced");
	write_cap_a: assert property (@(posedge core_clk) disable iff (rst)
		(active && wr_fall && !tx_full_q) |=> (tx_valid && tx_data == $past(data_s)))
		else $error("write byte not captured");
	space_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		tx_valid |-> tx_space_avail_n_o)
		else $error("space flag low while holding full");
	flag_reset_a: assert property (@(posedge core_clk)
		rst |-> !tx_space_avail_n_oe)
		else $error("space flag driven in reset");
	wake_req_a: assert property (@(posedge core_clk) disable iff (rst)
		(active && send_now_wakeup_n_fall && power_enable_n && wakeup_en) |=> resume_req ##1 !resume_req)
		else $error("resume not requested");
	flush_req_a: assert property (@(posedge core_clk) disable iff (rst)
		(active && send_now_wakeup_n_fall && !power_enable_n) |=> (send_now && !resume_req))
		else $error("flush not requested");
	avail_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		!rx_data_avail_n |-> (rx_valid && active))
		else $error("data flag low without data");
	mode_off_a: assert property (@(posedge core_clk) disable iff (rst)
		!active |-> (rx_data_avail_n && tx_space_avail_n_o))
		else $error("flags active with mode disabled");
	pop_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		rx_ready |=> !rx_ready)
		else $error("receive pop longer than one cycle");
	bus_release_a: assert property (@(posedge core_clk) disable iff (rst)
		(rd_state_q == APFP_RD_DRIVE && rd_rise) |=> !chan_data_oe)
		else $error("data bus held after read strobe rise");
	write_full_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_fall && tx_full_q && !tx_ready) |=> (tx_valid && tx_data == $past(tx_data)))
		else $error("held byte overwritten while full");
	space_oe_a: assert property (@(posedge core_clk)
		(!rst && !$past(rst)) |-> tx_space_avail_n_oe)
		else $error("space flag not driven after reset");
	send_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		send_now |=> !send_now)
		else $error("flush pulse longer than one cycle");
	wake_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(active && send_now_wakeup_n_fall && power_enable_n && !wakeup_en) |=> (!resume_req && !send_now))
		else $error("pulse raised while suspended without wakeup");
endmodule

// file: tb/apfp_master.sv
// external bus master model: strobes, send-now pin and data bus level
module apfp_master (
	// clock
	input  wire logic       core_clk,
	// device side of the data bus
	input  wire logic       dev_oe,
	input  wire logic [7:0] dev_o,
	// pins
	output logic [7:0]      bus,
	output logic            rd_n,
	output logic            wr_n,
	output logic            send_now_wakeup_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv;
	logic       drv_en;
	// released bus shows the inverse of the last byte, never a stale copy
	always_comb bus = dev_oe ? dev_o : (drv_en ? drv : ~drv);
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		send_now_wakeup_n = 1'b1;
		drv = 8'h00;
		drv_en = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// one read, bus sampled while the strobe is still low
	task automatic read_byte(output logic [7:0] b, output logic oe);
		drv_en = 1'b0;
		rd_n = 1'b0;
		gap(6);
		b = bus;
		oe = dev_oe;
		rd_n = 1'b1;
		gap(6);
	endtask
	// one write, data held well around the falling strobe
	task automatic write_byte(input logic [7:0] b);
		drv = b;
		drv_en = 1'b1;
		gap(2);
		wr_n = 1'b0;
		gap(6);
		wr_n = 1'b1;
		gap(6);
		drv_en = 1'b0;
	endtask
	task automatic pulse_send();
		send_now_wakeup_n = 1'b0;
		gap(6);
		send_now_wakeup_n = 1'b1;
		gap(6);
	endtask
endmodule

// file: tb/apfp_port_test.sv
// self-checking bench for the asynchronous fifo port
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, s); end end
module apfp_port_test;
	import apfp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk, rst, chan_sel, wakeup_en, power_enable_n;
	logic [1:0] fifo_mode_en;
	logic       rx_valid, rx_ready, tx_valid, tx_ready, send_now, resume_req;
	logic [7:0] rx_data, tx_data, chan_data_i, chan_data_o, rb;
	logic       chan_data_oe, rd_n, wr_n, send_now_wakeup_n, rx_data_avail_n;
	logic       tx_space_avail_n_o, tx_space_avail_n_oe, roe;
	int         bad_count, checks_done, n_pop, n_send, n_wake, cyc;
	apfp_port apfp_port_i (.core_clk(core_clk), .rst(rst), .fifo_mode_en(fifo_mode_en),
		.chan_sel(chan_sel), .wakeup_en(wakeup_en), .power_enable_n(power_enable_n),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .send_now(send_now),
		.resume_req(resume_req), .chan_data_i(chan_data_i), .chan_data_o(chan_data_o),
		.chan_data_oe(chan_data_oe), .rd_n(rd_n), .wr_n(wr_n),
		.send_now_wakeup_n(send_now_wakeup_n), .rx_data_avail_n(rx_data_avail_n),
		.tx_space_avail_n_o(tx_space_avail_n_o),
		.tx_space_avail_n_oe(tx_space_avail_n_oe));
	apfp_master apfp_master_i (.core_clk(core_clk), .dev_oe(chan_data_oe),
		.dev_o(chan_data_o), .bus(chan_data_i), .rd_n(rd_n), .wr_n(wr_n),
		.send_now_wakeup_n(send_now_wakeup_n));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// pulse counters and hang limit
	always @(posedge core_clk) begin
		cyc++;
		if (rx_ready === 1'b1) n_pop++;
		if (send_now === 1'b1) n_send++;
		if (resume_req === 1'b1) n_wake++;
		if (cyc == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic t_reset();
		repeat (15) @(negedge core_clk);
		`CHK("space oe in reset", 1'b0, tx_space_avail_n_oe)
		`CHK("bus oe in reset", 1'b0, chan_data_oe)
		@(negedge core_clk);
		rst = 1'b0;
		apfp_master_i.gap(4);
		`CHK("space oe", 1'b1, tx_space_avail_n_oe)
		`CHK("space flag", 1'b0, tx_space_avail_n_o)
		$display("test reset done");
	endtask
	task automatic t_read(input logic [7:0] b);
		rx_valid = 1'b1;
		rx_data = b;
		apfp_master_i.gap(4);
		`CHK("avail flag", 1'b0, rx_data_avail_n)
		apfp_master_i.read_byte(rb, roe);
		`CHK("oe while read", 1'b1, roe)
		`CHK("read byte", b, rb)
		`CHK("oe after read", 1'b0, chan_data_oe)
		`CHK("pops", 1, n_pop)
		rx_valid = 1'b0;
		apfp_master_i.gap(4);
		`CHK("empty flag", 1'b1, rx_data_avail_n)
		apfp_master_i.read_byte(rb, roe);
		`CHK("no pop on empty", 1, n_pop)
		$display("test read done");
	endtask
	task automatic t_write(input logic [7:0] b);
		apfp_master_i.write_byte(b);
		`CHK("tx valid", 1'b1, tx_valid)
		`CHK("tx byte", b, tx_data)
		`CHK("full flag", 1'b1, tx_space_avail_n_o)
		apfp_master_i.gap(2);
		apfp_master_i.write_byte(~b);
		`CHK("held byte", b, tx_data)
		`CHK("still full", 1'b1, tx_valid)
		tx_ready = 1'b1;
		apfp_master_i.gap(2);
		tx_ready = 1'b0;
		apfp_master_i.gap(1);
		`CHK("tx drained", 1'b0, tx_valid)
		`CHK("room flag", 1'b0, tx_space_avail_n_o)
		$display("test write done");
	endtask
	// one send-now pulse under a given power and wakeup setting
	task automatic send_case(input logic pwr, input logic wk, input int ex_send,
		input int ex_wake);
		power_enable_n = pwr;
		wakeup_en = wk;
		apfp_master_i.pulse_send();
		`CHK("flush count", ex_send, n_send)
		`CHK("resume count", ex_wake, n_wake)
	endtask
	task automatic t_send();
		send_case(1'b0, 1'b0, 1, 0);
		send_case(1'b1, 1'b1, 1, 1);
		send_case(1'b1, 1'b0, 1, 1);
		send_case(1'b0, 1'b1, 2, 1);
		$display("test send done");
	endtask
	task automatic t_chan_two();
		chan_sel = APFP_CHAN_TWO;
		fifo_mode_en = 2'b10;
		n_pop = 0;
		t_read(8'h5A);
		fifo_mode_en = 2'b01;
		rx_valid = 1'b1;
		apfp_master_i.gap(4);
		`CHK("disabled flag", 1'b1, rx_data_avail_n)
		rx_valid = 1'b0;
		$display("test channel two done");
	endtask
	initial begin
		rst = 1'b1;
		fifo_mode_en = 2'b11;
		chan_sel = APFP_CHAN_ONE;
		wakeup_en = 1'b0;
		power_enable_n = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		t_reset();
		t_read(8'hA5);
		t_write(8'h3C);
		t_send();
		t_chan_two();
		complete_run();
	end
endmodule
